//--- hw/bier_ev_if.sv
`include "bier_regs.svh"
// Event bundle between the detector and the register file.
interface bier_ev_if;
  logic [`BIER_M_W-1:0]   mod_set;
  logic [`BIER_B_W-1:0]   bus_set;
  logic                   capture;
  logic [`BIER_ADDR_W-1:0] cap_addr;
  logic [`BIER_CMD_W-1:0] cap_cmd;
  logic                   irq4_src;
  logic                   irq5_src;
  modport src (output mod_set, bus_set, capture, cap_addr, cap_cmd);
  modport dst (input mod_set, bus_set, capture, cap_addr, cap_cmd,
               output irq4_src, irq5_src);
endinterface : bier_ev_if

//--- hw/bier_pkg.sv
package bier_pkg;
  typedef enum logic [1:0] {BIER_ACK_NONE, BIER_ACK_OK, BIER_ACK_HERR}
    bier_ack_t;
  typedef enum {BIER_IDLE, BIER_GRANTED, BIER_WAIT_CNF} bier_tx_t;
endpackage : bier_pkg

//--- hw/bier_regfile.sv
`include "bier_regs.svh"
// Error registers with Wishbone slave; software clears by writing ones.
module bier_regfile
  import bier_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  bier_ev_if.dst           ev,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             check_en_o
);
  logic [`BIER_M_W-1:0]    mod_r, mod_nxt;
  logic [`BIER_B_W-1:0]    bus_r, bus_nxt;
  logic [`BIER_ADDR_W-1:0] addr_r, addr_nxt;
  logic [`BIER_CMD_W-1:0]  cmd_r, cmd_nxt;
  logic [`BIER_C_W-1:0]    ctl_r, ctl_nxt;
  logic                    ack_r, ack_nxt;
  logic [31:0]             dat_r, dat_nxt;
  logic                    wr;
  logic [31:0]             wm;
  always_comb
  begin
    // The write lands at the edge at which the master samples ack high.
    wr = cyc_i && stb_i && we_i && ack_r;
    wm = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                  {8{sel_i[0]}}};
    mod_nxt  = mod_r;
    bus_nxt  = bus_r;
    addr_nxt = addr_r;
    cmd_nxt  = cmd_r;
    ctl_nxt  = ctl_r;
    if (wr && adr_i == `BIER_MOD_ERR_OFF)
      mod_nxt = mod_r & ~wm[`BIER_M_W-1:0];
    if (wr && adr_i == `BIER_BUS_ERR_OFF)
      bus_nxt = bus_r & ~wm[`BIER_B_W-1:0];
    if (wr && adr_i == `BIER_CTL_OFF && sel_i[0])
      ctl_nxt = dat_i[`BIER_C_W-1:0];
    // Setting after clearing lets a new event win over a clear.
    mod_nxt = mod_nxt | ev.mod_set;
    bus_nxt = bus_nxt | ev.bus_set;
    // Capture only the first error, so the original cause is kept.
    if (ev.capture && !bus_r[`BIER_B_NODE_SPECIFIC_ERROR_SUMMARY] && !bus_r[`BIER_B_NONEXISTENT_ADDRESS_FLAG])
    begin
      addr_nxt = ev.cap_addr;
      cmd_nxt  = ev.cap_cmd;
    end
    ack_nxt = cyc_i && stb_i && !ack_r;
    unique case (adr_i)
      `BIER_MOD_ERR_OFF:  dat_nxt = 32'(mod_r);
      `BIER_BUS_ERR_OFF:  dat_nxt = 32'(bus_r);
      `BIER_CAP_ADDR_OFF: dat_nxt = 32'(addr_r);
      `BIER_CAP_CMD_OFF:  dat_nxt = 32'(cmd_r);
      `BIER_CTL_OFF:      dat_nxt = 32'(ctl_r);
      default:            dat_nxt = 32'h0;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mod_r  <= '0;
      bus_r  <= '0;
      addr_r <= '0;
      cmd_r  <= '0;
      ctl_r  <= `BIER_CTL_RST;
      ack_r  <= 1'b0;
      dat_r  <= '0;
    end
    else
    begin
      mod_r  <= mod_nxt;
      bus_r  <= bus_nxt;
      addr_r <= addr_nxt;
      cmd_r  <= cmd_nxt;
      ctl_r  <= ctl_nxt;
      ack_r  <= ack_nxt;
      dat_r  <= dat_nxt;
    end
  end
  assign ack_o      = ack_r;
  assign dat_o      = dat_r;
  assign check_en_o = ctl_r[`BIER_C_CHECK_EN];
  // Line 4 flags: status parity from either side, drop, nonexistent address.
  assign ev.irq4_src = mod_r[`BIER_M_ARBITRATION_DROP_FLAG] | bus_r[`BIER_B_NONEXISTENT_ADDRESS_FLAG]
                     | mod_r[`BIER_M_STATPE];
  assign ev.irq5_src = mod_r[`BIER_M_PMAPPE] | mod_r[`BIER_M_BACKUP_MAP_PARITY_FLAG]
                     | mod_r[`BIER_M_ARBITRATION_COLLISION_FLAG]
                     | (|bus_r[`BIER_B_STE:`BIER_B_CMD_TRANSMIT_CHECK_FLAG]);
endmodule : bier_regfile

//--- hw/bier_regs.svh
`ifndef BIER_REGS_SVH
`define BIER_REGS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define BIER_MOD_ERR_OFF   8'h00
`define BIER_BUS_ERR_OFF   8'h04
`define BIER_CAP_ADDR_OFF  8'h08
`define BIER_CAP_CMD_OFF   8'h0c
`define BIER_CTL_OFF       8'h10
// ----------------------------------------------------------------
// Module error register fields
// ----------------------------------------------------------------
`define BIER_M_STATPE      0
`define BIER_M_TAGPE       1
`define BIER_M_PMAPPE      2
`define BIER_M_BACKUP_MAP_PARITY_FLAG      3
`define BIER_M_ARBITRATION_DROP_FLAG     4
`define BIER_M_ARBITRATION_COLLISION_FLAG      5
`define BIER_M_W           6
// ----------------------------------------------------------------
// Bus error summary register fields
// ----------------------------------------------------------------
`define BIER_B_NODE_SPECIFIC_ERROR_SUMMARY        0
`define BIER_B_CMD_TRANSMIT_CHECK_FLAG        1
`define BIER_B_DATA_TRANSMIT_CHECK_FLAG        2
`define BIER_B_DIE         3
`define BIER_B_SHE         4
`define BIER_B_CAE         5
`define BIER_B_CONFIRM_MISUSE_ERROR        6
`define BIER_B_STE         7
`define BIER_B_NONEXISTENT_ADDRESS_FLAG        8
`define BIER_B_TDE         9
`define BIER_B_W           10
// ----------------------------------------------------------------
// Control register fields and timing
// ----------------------------------------------------------------
`define BIER_C_CHECK_EN    0
`define BIER_C_W           1
`define BIER_CTL_RST       1'h1
`define BIER_CNF_WAIT      4'h3
`define BIER_ARB_WAIT      4'h2
`define BIER_ADDR_W        32
`define BIER_CMD_W         4
`endif

//--- hw/bier_sync.sv
// Two-stage synchroniser for a group of pins.
module bier_sync #(parameter int W = 1)
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;
  always_comb
  begin
    s1_nxt = d_i;
    q_nxt  = s1_r;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= '0;
      q_r  <= '0;
    end
    else
    begin
      s1_r <= s1_nxt;
      q_r  <= q_nxt;
    end
  end
  assign q_o = q_r;
endmodule : bier_sync

//--- hw/bier_top.sv
`include "bier_regs.svh"
// Operation
// (R1) Status parity error on processor request returns hard-error acknowledgment.
// (R2) Status parity error on bus request raises interrupt line 4.
// (R3) Processor vectors hard-error ack and interrupts per its own priorities.
// (R4) Every reported error also asserts the bus ERROR line.
// (R5) Status parity sets status flag, summary flag, captures address and command.
// (R6) Status or backup-map parity error: ERROR on, SHARED and DIRTY off.
// (R7) Tag parity checked for processor only; hard-error ack, flags, capture.
// (R8) Primary-map parity on bus write backup hit: line 5, flags, capture.
// (R9) Primary-map error: DIRTY from backup map, SHARED asserted.
// (R10) Backup-map parity on bus lookup: line 5, flags, capture.
// (R11) Granted node without strobe: drop flag; hard-error ack or line 4.
// (R12) Request lines in forbidden cycle: line 5, collision flag, no capture.
// (R13) Driven command or data mismatching bus readback: line 5, check flag.
// (R14) Misplaced DIRTY, SHARED, strobe, confirm or STALL: line 5, misuse flag.
// (R15) Missing confirm: nonexistent flag, capture; hard-error ack or line 4.
// (R16) Missing-confirm transaction still runs its data cycles.
// (R17) Node driving at ERROR sets driving flag; never causes ERROR itself.
// (R18) Arbitration state resynchronises whenever bus ERROR is asserted.
// (R19) Asynchronous errors assert a module-level error signal.
// (R20) Interrupt lines stay high while any routed flag remains set.
module bier_top
  import bier_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Cache-side check results, same clock.
  input  wire logic        proc_req_i,
  input  wire logic        proc_done_i,
  input  wire logic        stat_pe_proc_i,
  input  wire logic        stat_pe_bus_i,
  input  wire logic        tag_pe_i,
  input  wire logic        bmap_lookup_i,
  input  wire logic        bmap_pe_i,
  input  wire logic        bmap_hit_i,
  input  wire logic        bmap_dirty_i,
  input  wire logic        bus_write_i,
  input  wire logic        pmap_pe_i,
  input  wire logic        pmap_hit_i,
  input  wire logic [31:0] req_addr_i,
  input  wire logic [3:0]  req_cmd_i,
  // Arbitration and transmit view, same clock.
  input  wire logic        grant_i,
  input  wire logic        grant_own_i,
  input  wire logic        req_allowed_i,
  input  wire logic        tx_drive_i,
  input  wire logic [31:0] tx_word_i,
  input  wire logic        tx_is_cmd_i,
  input  wire logic [4:0]  allowed_i,
  // Bus pins.
  input  wire logic        bus_req_i,
  input  wire logic        bus_strobe_i,
  input  wire logic        bus_confirm_i,
  input  wire logic        bus_shared_i,
  input  wire logic        bus_dirty_i,
  input  wire logic        bus_stall_i,
  input  wire logic        bus_error_i,
  input  wire logic [31:0] bus_word_i,
  // Outputs.
  output logic [1:0]       proc_ack_o,
  output logic             irq4_o,
  output logic             irq5_o,
  output logic             module_error_o,
  output logic             bus_error_o,
  output logic             bus_shared_o,
  output logic             bus_dirty_o,
  output logic             arb_resync_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [38:0] pins_s;
  logic        s_req, s_str, s_cnf, s_shr, s_drt, s_stl, s_err;
  logic [31:0] s_word;
  bier_sync #(.W(39)) u_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({bus_req_i, bus_strobe_i, bus_confirm_i, bus_shared_i,
             bus_dirty_i, bus_stall_i, bus_error_i, bus_word_i}),
    .q_o   (pins_s)
  );
  assign {s_req, s_str, s_cnf, s_shr, s_drt, s_stl, s_err, s_word} = pins_s;
  // The same-clock view is delayed as far as the pins are, so a good echo
  // is never held against a word driven two cycles later.
  logic [39:0] view_d;
  logic        d_drive, d_cmd, d_req_ok;
  logic [4:0]  d_allowed;
  logic [31:0] d_word;
  bier_sync #(.W(40)) u_align
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({tx_drive_i, tx_is_cmd_i, req_allowed_i, allowed_i, tx_word_i}),
    .q_o   (view_d)
  );
  assign {d_drive, d_cmd, d_req_ok, d_allowed, d_word} = view_d;

  bier_ev_if ev ();
  logic check_en;
  bier_regfile u_regs
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ev         (ev),
    .cyc_i      (wb_cyc_i),
    .stb_i      (wb_stb_i),
    .we_i       (wb_we_i),
    .adr_i      (wb_adr_i),
    .sel_i      (wb_sel_i),
    .dat_i      (wb_dat_i),
    .dat_o      (wb_dat_o),
    .ack_o      (wb_ack_o),
    .check_en_o (check_en)
  );

  // ----------------------------------------------------------------
  // Transaction tracking
  // ----------------------------------------------------------------
  bier_tx_t    st_r, st_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic        own_r, own_nxt;
  logic        drop_ev, nxa_ev;
  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    own_nxt = own_r;
    drop_ev = 1'b0;
    nxa_ev  = 1'b0;
    if (s_err)
      st_nxt = BIER_IDLE; // R18
    else
      unique case (st_r)
        BIER_IDLE:
          if (grant_i)
          begin
            st_nxt  = BIER_GRANTED;
            cnt_nxt = `BIER_ARB_WAIT;
            own_nxt = grant_own_i;
          end
        BIER_GRANTED:
          if (s_str)
          begin
            st_nxt  = BIER_WAIT_CNF;
            cnt_nxt = `BIER_CNF_WAIT;
          end
          else if (cnt_r == 4'h0)
          begin
            drop_ev = 1'b1; // R11
            st_nxt  = BIER_IDLE;
          end
          else
            cnt_nxt = cnt_r - 4'h1;
        BIER_WAIT_CNF:
          if (s_cnf)
            st_nxt = BIER_IDLE;
          else if (cnt_r == 4'h0)
          begin
            // Data cycles are not aborted; only the flag is raised.
            nxa_ev = 1'b1; // R15 R16
            st_nxt = BIER_IDLE;
          end
          else
            cnt_nxt = cnt_r - 4'h1;
      endcase
  end

  // ----------------------------------------------------------------
  // Error detection
  // ----------------------------------------------------------------
  logic        pmap_ev, bmap_ev, tag_ev, cmd_transmit_check_flag, data_transmit_check_flag, col_ev;
  logic [4:0]  misuse;
  logic        sync_err;
  logic        bus_error_r, bus_error_nxt;
  always_comb
  begin
    tag_ev  = tag_pe_i && proc_req_i; // R7
    bmap_ev = bmap_lookup_i && bmap_pe_i; // R10
    pmap_ev = bus_write_i && bmap_hit_i && pmap_pe_i; // R8
    col_ev  = s_req && !d_req_ok; // R12
    cmd_transmit_check_flag    = check_en && d_drive && d_cmd
              && (d_word != s_word); // R13
    data_transmit_check_flag    = check_en && d_drive && !d_cmd
              && (d_word != s_word); // R13
    misuse  = {s_stl, s_cnf, s_str, s_shr, s_drt} & ~d_allowed; // R14
    sync_err = (stat_pe_proc_i && proc_req_i) || tag_ev
               || (proc_req_i && own_r && (drop_ev || nxa_ev));
    ev.mod_set = {col_ev, drop_ev, bmap_ev, pmap_ev, tag_ev,
                  stat_pe_proc_i | stat_pe_bus_i}; // R5 R7 R8 R10 R11 R12
    ev.bus_set = '0;
    ev.bus_set[`BIER_B_NODE_SPECIFIC_ERROR_SUMMARY] = (|ev.mod_set); // R5
    ev.bus_set[`BIER_B_CMD_TRANSMIT_CHECK_FLAG] = cmd_transmit_check_flag;
    ev.bus_set[`BIER_B_DATA_TRANSMIT_CHECK_FLAG] = data_transmit_check_flag;
    ev.bus_set[`BIER_B_STE:`BIER_B_DIE] = misuse; // R14
    ev.bus_set[`BIER_B_NONEXISTENT_ADDRESS_FLAG] = nxa_ev; // R15
    // Set only when another node raised ERROR while this node drove.
    ev.bus_set[`BIER_B_TDE] = s_err && !bus_error_r && d_drive; // R17
    ev.capture  = stat_pe_proc_i | stat_pe_bus_i | tag_ev | pmap_ev
                  | bmap_ev | drop_ev | nxa_ev; // R5 R15
    ev.cap_addr = req_addr_i;
    ev.cap_cmd  = req_cmd_i;
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic [1:0] ack_r, ack_nxt;
  logic       irq4_r, irq4_nxt, irq5_r, irq5_nxt;
  logic       merr_r, merr_nxt;
  logic       shr_r, shr_nxt, drt_r, drt_nxt;
  logic       rs_r, rs_nxt;
  logic       async_ev;
  always_comb
  begin
    async_ev = stat_pe_bus_i | pmap_ev | bmap_ev | col_ev | cmd_transmit_check_flag | data_transmit_check_flag
               | (|misuse) | ((drop_ev | nxa_ev) & !(proc_req_i && own_r));
    ack_nxt = BIER_ACK_NONE;
    if (proc_req_i && sync_err)
      ack_nxt = BIER_ACK_HERR; // R1 R7 R11 R15
    else if (proc_done_i)
      ack_nxt = BIER_ACK_OK;
    // The routed flags keep the line high until software clears them.
    irq4_nxt = ev.irq4_src; // R2 R11 R15 R20
    irq5_nxt = ev.irq5_src; // R8 R10 R12 R13 R14 R20
    merr_nxt = irq4_nxt | irq5_nxt; // R19
    // Driving-node flag is excluded here so it never raises ERROR.
    bus_error_nxt = sync_err | async_ev; // R4 R17
    shr_nxt = 1'b0;
    drt_nxt = 1'b0;
    if (stat_pe_bus_i || bmap_ev)
    begin
      shr_nxt = 1'b0; // R6
      drt_nxt = 1'b0; // R6
    end
    else if (pmap_ev)
    begin
      shr_nxt = 1'b1; // R9
      drt_nxt = bmap_dirty_i; // R9
    end
    else if (bmap_lookup_i && bmap_hit_i)
    begin
      shr_nxt = pmap_hit_i;
      drt_nxt = bmap_dirty_i;
    end
    rs_nxt = s_err; // R18
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r        <= BIER_IDLE;
      cnt_r       <= '0;
      own_r       <= 1'b0;
      ack_r       <= BIER_ACK_NONE;
      irq4_r      <= 1'b0;
      irq5_r      <= 1'b0;
      bus_error_r <= 1'b0;
      shr_r       <= 1'b0;
      drt_r       <= 1'b0;
      rs_r        <= 1'b0;
      merr_r      <= 1'b0;
    end
    else
    begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      own_r       <= own_nxt;
      ack_r       <= ack_nxt;
      irq4_r      <= irq4_nxt;
      irq5_r      <= irq5_nxt;
      bus_error_r <= bus_error_nxt;
      shr_r       <= shr_nxt;
      drt_r       <= drt_nxt;
      rs_r        <= rs_nxt;
      merr_r      <= merr_nxt;
    end
  end
  assign proc_ack_o     = ack_r;
  assign irq4_o         = irq4_r;
  assign irq5_o         = irq5_r;
  assign module_error_o = merr_r; // R19
  assign bus_error_o    = bus_error_r;
  assign bus_shared_o   = shr_r;
  assign bus_dirty_o    = drt_r;
  assign arb_resync_o   = rs_r;
endmodule : bier_top

//--- testbench/bier_bus_node.sv
// Other bus nodes: answer a strobe with confirm and echo our driven word.
module bier_bus_node
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        strobe_i,
  input  wire logic        cnf_en_i,
  input  wire logic        flip_i,
  input  wire logic        tx_drive_i,
  input  wire logic [31:0] tx_word_i,
  input  wire logic        error_i,
  output logic             confirm_o,
  output logic      [31:0] word_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]  pend_r;
  logic [31:0] last_r;
  always @(posedge clk_i)
  begin
    if (rst_i || error_i)
      pend_r <= 2'h0;
    else
      pend_r <= {pend_r[0], strobe_i & cnf_en_i};
    if (rst_i)
      last_r <= 32'h0;
    else if (tx_drive_i)
      last_r <= word_o;
  end
  assign confirm_o = pend_r[1];
  // Released lines show the inverse, so a stale word never passes as echo.
  assign word_o = tx_drive_i ? tx_word_i ^ {31'h0, flip_i} : ~last_r;
endmodule : bier_bus_node

//--- testbench/bier_top_properties.sv
module bier_top_properties
  import bier_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  input wire logic       proc_req_i,
  input wire logic       stat_pe_proc_i,
  input wire logic       stat_pe_bus_i,
  input wire logic       tag_pe_i,
  input wire logic       bmap_lookup_i,
  input wire logic       bmap_pe_i,
  input wire logic       bmap_hit_i,
  input wire logic       bmap_dirty_i,
  input wire logic       bus_write_i,
  input wire logic       pmap_pe_i,
  input wire logic       bus_error_i,
  input wire logic [1:0] proc_ack_o,
  input wire logic       irq4_o,
  input wire logic       irq5_o,
  input wire logic       module_error_o,
  input wire logic       bus_error_o,
  input wire logic       bus_shared_o,
  input wire logic       bus_dirty_o,
  input wire logic       arb_resync_o
);
  logic wr_ack;
  assign wr_ack = wb_we_i && wb_ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_herr;
    proc_ack_o == BIER_ACK_HERR && bus_error_o;
  endsequence
  sequence s_pmap_err;
    bmap_lookup_i && bmap_hit_i && bus_write_i && pmap_pe_i && !bmap_pe_i;
  endsequence
  a_stat_herr:
    assert property (stat_pe_proc_i && proc_req_i |=> s_herr)
    else $error("status parity gave no hard-error ack");
  a_tag_herr:
    assert property (tag_pe_i && proc_req_i |=> s_herr)
    else $error("tag parity gave no hard-error ack");
  a_stat_irq4:
    assert property (stat_pe_bus_i |-> ##2 irq4_o)
    else $error("bus status parity did not raise line 4");
  a_quiet_err:
    assert property (stat_pe_bus_i || bmap_lookup_i && bmap_pe_i |=>
      bus_error_o && !bus_shared_o && !bus_dirty_o)
    else $error("parity response not error-only");
  a_pmap_share:
    assert property (s_pmap_err |=>
      bus_shared_o && bus_dirty_o == $past(bmap_dirty_i))
    else $error("primary map error response wrong");
  a_pmap_irq5:
    assert property (s_pmap_err |-> ##2 irq5_o)
    else $error("primary map error did not raise line 5");
  a_err_summary:
    assert property (module_error_o == (irq4_o || irq5_o))
    else $error("module error signal not the or of the lines");
  a_err_resync:
    assert property ($rose(bus_error_i) |-> ##[1:4] arb_resync_o)
    else $error("bus error did not resynchronise arbitration");
  a_irq_hold:
    assert property (!$past(rst_i) && ($fell(irq4_o) || $fell(irq5_o)) |->
      $past(wr_ack) || $past(wr_ack, 2) || $past(wr_ack, 3))
    else $error("interrupt line fell without a clear");
  a_wb_ack_once:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");
endmodule : bier_top_properties
bind bier_top bier_top_properties u_bier_top_properties (.*);

//--- testbench/tb_bier_top.sv
`include "bier_regs.svh"
module tb_bier_top
  import bier_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, proc = 0, own = 0;
  logic cmd = 0, txh = 0, cnf_en = 1, req_ok = 1, mon_clr = 0, confirm_signal;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, word, addr = 32'h1234_5678, wb_dat_o;
  logic [3:0]  kind = 4'h9, mon = 4'h0;
  logic [10:0] ev = 0;
  logic [8:0]  pin = 0;
  logic [4:0]  allow = 5'h1f;
  logic [1:0]  proc_ack_o;
  logic wb_ack_o, irq4_o, irq5_o, bus_error_o, bus_shared_o, bus_dirty_o;
  logic txd;
  int n_mismatch = 0, tests_run = 0;
  assign txd = pin[6] | txh;
  always #25 clk_i = ~clk_i;
  // Sticky view of one-cycle outputs: {hard error, ERROR, SHARED, DIRTY}.
  always @(posedge clk_i)
    mon <= mon_clr ? 4'h0 : mon | {proc_ack_o === BIER_ACK_HERR,
      bus_error_o === 1'b1, bus_shared_o === 1'b1, bus_dirty_o === 1'b1};
  bier_top u_bier_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .proc_req_i(proc),
    .proc_done_i(1'b0), .stat_pe_proc_i(ev[0]), .stat_pe_bus_i(ev[1]),
    .tag_pe_i(ev[2]), .bmap_lookup_i(ev[3]), .bmap_pe_i(ev[4]),
    .bmap_hit_i(ev[5]), .bmap_dirty_i(ev[6]), .bus_write_i(ev[7]),
    .pmap_pe_i(ev[8]), .pmap_hit_i(ev[9]), .req_addr_i(addr),
    .req_cmd_i(kind), .grant_i(ev[10]), .grant_own_i(own),
    .req_allowed_i(req_ok), .tx_drive_i(txd), .tx_word_i(32'h5a5a_0f0f),
    .tx_is_cmd_i(cmd), .allowed_i(allow), .bus_req_i(pin[5]),
    .bus_strobe_i(pin[2]), .bus_confirm_i(pin[3] | confirm_signal),
    .bus_shared_i(pin[1]), .bus_dirty_i(pin[0]), .bus_stall_i(pin[4]),
    .bus_error_i(pin[8]), .bus_word_i(word), .proc_ack_o(proc_ack_o),
    .irq4_o(irq4_o), .irq5_o(irq5_o), .module_error_o(),
    .bus_error_o(bus_error_o), .bus_shared_o(bus_shared_o),
    .bus_dirty_o(bus_dirty_o), .arb_resync_o());
  bier_bus_node u_bier_bus_node (
    .clk_i(clk_i), .rst_i(rst_i), .strobe_i(pin[2]), .cnf_en_i(cnf_en),
    .flip_i(pin[7]), .tx_drive_i(txd), .tx_word_i(32'h5a5a_0f0f),
    .error_i(pin[8]), .confirm_o(confirm_signal), .word_o(word));
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i iff wb_ack_o === 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
  endtask : wb
  task automatic pulse(input logic [10:0] e, input logic [8:0] p);
    @(posedge clk_i);
    ev <= e;
    pin <= p;
    mon_clr <= 1'b1;
    @(posedge clk_i);
    ev <= 11'h0;
    pin <= 9'h0;
    mon_clr <= 1'b0;
  endtask : pulse
  // The irq mask skips lines whose level is left open when a hard-error
  // ack is the report.
  task automatic judge(input logic [3:0] m, input logic [1:0] ic,
                       input logic [1:0] i, input logic [31:0] me, be);
    repeat (12) @(posedge clk_i);
    chk(mon, m);
    chk({irq4_o, irq5_o} & ic, i);
    wb(1'b0, `BIER_MOD_ERR_OFF, 32'h0);
    chk(rdat, me);
    wb(1'b0, `BIER_BUS_ERR_OFF, 32'h0);
    chk(rdat, be);
    wb(1'b1, `BIER_MOD_ERR_OFF, 32'hffff_ffff);
    wb(1'b1, `BIER_BUS_ERR_OFF, 32'hffff_ffff);
    repeat (4) @(posedge clk_i);
    chk({irq4_o, irq5_o}, 2'h0);
  endtask : judge
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs;
    wb(1'b0, `BIER_CTL_OFF, 32'h0);
    chk(rdat, 32'h1);
    wb(1'b1, 8'h14, 32'hffff_ffff);
    wb(1'b0, 8'h14, 32'h0);
    chk(rdat, 32'h0);
    judge(4'h0, 2'h3, 2'h0, 32'h0, 32'h0);
  endtask : t_regs
  task automatic t_stat;
    proc <= 1'b1;
    pulse(11'h001, 9'h0);
    judge(4'hc, 2'h0, 2'h0, 32'h1, 32'h1);
    wb(1'b1, `BIER_CAP_ADDR_OFF, 32'h0);
    wb(1'b0, `BIER_CAP_ADDR_OFF, 32'h0);
    chk(rdat, addr);
    wb(1'b0, `BIER_CAP_CMD_OFF, 32'h0);
    chk(rdat, {28'h0, kind});
    pulse(11'h002, 9'h0);
    judge(4'h4, 2'h2, 2'h2, 32'h1, 32'h1);
  endtask : t_stat
  task automatic t_tag;
    pulse(11'h004, 9'h0);
    judge(4'hc, 2'h0, 2'h0, 32'h2, 32'h1);
    proc <= 1'b0;
    pulse(11'h004, 9'h0);
    judge(4'h0, 2'h3, 2'h0, 32'h0, 32'h0);
  endtask : t_tag
  task automatic t_maps;
    pulse(11'h1e8, 9'h0);
    judge(4'h7, 2'h1, 2'h1, 32'h4, 32'h1);
    pulse(11'h018, 9'h0);
    judge(4'h4, 2'h1, 2'h1, 32'h8, 32'h1);
  endtask : t_maps
  task automatic t_arb;
    proc <= 1'b1;
    own <= 1'b1;
    pulse(11'h400, 9'h0);
    judge(4'hc, 2'h0, 2'h0, 32'h10, 32'h1);
    own <= 1'b0;
    pulse(11'h400, 9'h0);
    judge(4'h4, 2'h2, 2'h2, 32'h10, 32'h1);
    own <= 1'b1;
    cnf_en <= 1'b0;
    pulse(11'h400, 9'h004);
    judge(4'hc, 2'h0, 2'h0, 32'h0, 32'h100);
    cnf_en <= 1'b1;
    pulse(11'h400, 9'h004);
    judge(4'h0, 2'h3, 2'h0, 32'h0, 32'h0);
    proc <= 1'b0;
  endtask : t_arb
  task automatic t_coll;
    req_ok <= 1'b0;
    addr <= 32'h0bad_0001;
    pulse(11'h0, 9'h020);
    repeat (4) @(posedge clk_i);
    req_ok <= 1'b1;
    judge(4'h4, 2'h1, 2'h1, 32'h20, 32'h1);
    wb(1'b0, `BIER_CAP_ADDR_OFF, 32'h0);
    chk(rdat, 32'h1234_5678);
  endtask : t_coll
  task automatic t_misuse;
    for (int i = 0; i < 5; i++)
    begin
      allow <= 5'h1f ^ (5'h1 << i);
      pulse(11'h0, 9'h1 << i);
      judge(4'h4, 2'h1, 2'h1, 32'h0, 32'h8 << i);
    end
    allow <= 5'h1f;
  endtask : t_misuse
  task automatic t_tx;
    cmd <= 1'b1;
    pulse(11'h0, 9'h0c0);
    judge(4'h4, 2'h1, 2'h1, 32'h0, 32'h2);
    cmd <= 1'b0;
    pulse(11'h0, 9'h0c0);
    judge(4'h4, 2'h1, 2'h1, 32'h0, 32'h4);
    pulse(11'h0, 9'h040);
    judge(4'h0, 2'h3, 2'h0, 32'h0, 32'h0);
    wb(1'b1, `BIER_CTL_OFF, 32'h0);
    pulse(11'h0, 9'h0c0);
    judge(4'h0, 2'h3, 2'h0, 32'h0, 32'h0);
    wb(1'b1, `BIER_CTL_OFF, 32'h1);
  endtask : t_tx
  task automatic t_drv;
    txh <= 1'b1;
    pulse(11'h0, 9'h100);
    judge(4'h0, 2'h3, 2'h0, 32'h0, 32'h200);
    txh <= 1'b0;
  endtask : t_drv
  task automatic print_verdict;
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_stat;
    t_tag;
    t_maps;
    t_arb;
    t_coll;
    t_misuse;
    t_tx;
    t_drv;
    print_verdict;
  end
endmodule : tb_bier_top
